// *** core/gpiop_top.sv ***
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module gpiop_top #(
   parameter int PORTS = gpiop_pkg::GPIOP_PORTS_MAX
) (
   input  wire logic                                          clk_i,
   input  wire logic                                          rst_i,
   input  wire logic                                          ce_i,
   input  wire logic [7:0]                                    wb_adr_i,
   input  wire logic [31:0]                                   wb_dat_i,
   input  wire logic [3:0]                                    wb_sel_i,
   input  wire logic                                          wb_we_i,
   input  wire logic                                          wb_cyc_i,
   input  wire logic                                          wb_stb_i,
   output logic      [31:0]                                   wb_dat_o,
   output logic                                               wb_ack_o,
   input  wire logic [PORTS*gpiop_pkg::GPIOP_WIDTH-1:0]       pin_i,
   output logic      [PORTS*gpiop_pkg::GPIOP_WIDTH-1:0]       pin_o,
   output logic      [PORTS*gpiop_pkg::GPIOP_WIDTH-1:0]       pin_oe_o,
   input  wire logic                                          remap_pin_zero_out_i,
   input  wire logic                                          remap_pin_one_out_i,
   output logic                                               remap_pin_zero_in_o,
   output logic                                               remap_pin_one_in_o,
   input  wire logic                                          host_port_addr_six_out_i,
   input  wire logic                                          host_port_addr_six_oe_i,
   output logic                                               host_port_addr_six_in_o,
   input  wire logic                                          host_port_addr_seven_out_i,
   output logic                                               host_port_addr_seven_in_o,
   output logic                                               bandgap_drive_o
);
   import gpiop_pkg::*;

   localparam int N = PORTS * GPIOP_WIDTH;

   // =========================================================
   // State.
   // =========================================================
   typedef struct packed {
      logic [N-1:0]              dir;
      logic [N-1:0]              drive;
      logic [N-1:0]              ansel;
      logic [GPIOP_FN_WIDTH-1:0] func;
      logic [7:0]                wdctl;
      logic [N-1:0]              pin_out;
      logic [N-1:0]              pin_oe;
      logic [N-1:0]              level;
      logic                      rp0_in;
      logic                      rp1_in;
      logic                      ha6_in;
      logic                      ha7_in;
      logic                      bg;
      logic [31:0]               rdat;
      logic                      ack;
   } gpiop_state_t;

   gpiop_state_t s_q;
   gpiop_state_t s_d;

   logic [N-1:0] pad_o_w;
   logic [N-1:0] pad_oe_w;
   logic [N-1:0] din_w;

   // =========================================================
   // Pin muxes.
   // =========================================================
   for (genvar i = 0; i < N; i++) begin : g_pin
      gpiop_pin_if pif ();
      logic ovr_en;
      logic ovr_oe;
      logic ovr_out;
      logic kill;
      always_comb begin
         ovr_en  = 1'b0;
         ovr_oe  = 1'b0;
         ovr_out = 1'b0;
         kill    = 1'b0;
         if (i == GPIOP_PIN_ZERO) begin
            if (s_q.func[GPIOP_FN_HADDR6]) begin
               ovr_en  = 1'b1;
               ovr_oe  = host_port_addr_six_oe_i;
               ovr_out = host_port_addr_six_out_i;
            end else if (s_q.func[GPIOP_FN_REMAP0]) begin
               ovr_en  = 1'b1;
               ovr_oe  = ~s_q.dir[i];
               ovr_out = remap_pin_zero_out_i;
            end
         end else if (i == GPIOP_PIN_ONE) begin
            if (s_q.wdctl[GPIOP_WD_BGOE]) begin
               ovr_en  = 1'b1;
               kill    = 1'b1;
            end else if (s_q.func[GPIOP_FN_HADDR7]) begin
               ovr_en  = 1'b1;
               ovr_oe  = ~s_q.dir[i];
               ovr_out = host_port_addr_seven_out_i;
            end else if (s_q.func[GPIOP_FN_REMAP1]) begin
               ovr_en  = 1'b1;
               ovr_oe  = ~s_q.dir[i];
               ovr_out = remap_pin_one_out_i;
            end
         end else if (i == GPIOP_PIN_TWO) begin
            if (s_q.func[GPIOP_FN_CMPREF]) begin
               ovr_en  = 1'b1;
               kill    = 1'b1;
            end
         end
      end
      assign pif.dir     = s_q.dir[i];
      assign pif.drive   = s_q.drive[i];
      assign pif.analog  = s_q.ansel[i];
      assign pif.pin_in  = pin_i[i];
      assign pif.ovr_en  = ovr_en;
      assign pif.ovr_oe  = ovr_oe;
      assign pif.ovr_out = ovr_out;
      assign pif.in_kill = kill;
      assign pad_o_w[i]  = pif.pad_o;
      assign pad_oe_w[i] = pif.pad_oe;
      assign din_w[i]    = pif.din;
      gpiop_pin u_pin (
         .p (pif.port)
      );
   end

   // =========================================================
   // Bus decode and next state.
   // =========================================================
   logic [7:0] port_idx;
   logic [7:0] reg_off;
   logic       hit;

   always_comb begin
      s_d      = s_q;
      port_idx = wb_adr_i / GPIOP_PORT_STRIDE;
      reg_off  = wb_adr_i % GPIOP_PORT_STRIDE;
      hit      = wb_cyc_i & wb_stb_i & ~s_q.ack;
      // Pins are sampled every cycle that ce_i is high, so a level read sees one cycle of latency.
      s_d.level   = din_w;
      s_d.pin_out = pad_o_w;
      s_d.pin_oe  = pad_oe_w;
      s_d.rp0_in  = din_w[GPIOP_PIN_ZERO];
      s_d.rp1_in  = din_w[GPIOP_PIN_ONE];
      s_d.ha6_in  = din_w[GPIOP_PIN_ZERO];
      s_d.ha7_in  = din_w[GPIOP_PIN_ONE];
      s_d.bg      = s_q.wdctl[GPIOP_WD_BGOE];
      s_d.ack     = hit;
      s_d.rdat    = 32'h0000_0000;
      if (hit) begin
         if (port_idx < 8'(PORTS)) begin
            if (reg_off == GPIOP_OFF_DIR) begin
               s_d.rdat[7:0] = s_q.dir[port_idx*GPIOP_WIDTH +: GPIOP_WIDTH];
               if (wb_we_i && wb_sel_i[0]) begin
                  s_d.dir[port_idx*GPIOP_WIDTH +: GPIOP_WIDTH] = wb_dat_i[7:0];
               end
            end else if (reg_off == GPIOP_OFF_LEVEL) begin
               s_d.rdat[7:0] = s_q.level[port_idx*GPIOP_WIDTH +: GPIOP_WIDTH];
               if (wb_we_i && wb_sel_i[0]) begin
                  s_d.drive[port_idx*GPIOP_WIDTH +: GPIOP_WIDTH] = wb_dat_i[7:0];
               end
            end else if (reg_off == GPIOP_OFF_DRIVE) begin
               s_d.rdat[7:0] = s_q.drive[port_idx*GPIOP_WIDTH +: GPIOP_WIDTH];
               if (wb_we_i && wb_sel_i[0]) begin
                  s_d.drive[port_idx*GPIOP_WIDTH +: GPIOP_WIDTH] = wb_dat_i[7:0];
               end
            end else if (reg_off == GPIOP_OFF_ANSEL) begin
               s_d.rdat[7:0] = s_q.ansel[port_idx*GPIOP_WIDTH +: GPIOP_WIDTH];
               if (wb_we_i && wb_sel_i[0]) begin
                  s_d.ansel[port_idx*GPIOP_WIDTH +: GPIOP_WIDTH] = wb_dat_i[7:0];
               end
            end
         end else if (wb_adr_i == GPIOP_OFF_FUNC) begin
            s_d.rdat[GPIOP_FN_WIDTH-1:0] = s_q.func;
            if (wb_we_i && wb_sel_i[0]) begin
               s_d.func = wb_dat_i[GPIOP_FN_WIDTH-1:0];
            end
         end else if (wb_adr_i == GPIOP_OFF_WDCTL) begin
            s_d.rdat[7:0] = s_q.wdctl;
            if (wb_we_i && wb_sel_i[0]) begin
               s_d.wdctl = wb_dat_i[7:0];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q       <= '0;
         s_q.dir   <= {PORTS{GPIOP_DIR_RESET}};
         s_q.ansel <= {PORTS{GPIOP_ANSEL_RESET}};
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o                  = s_q.rdat;
   assign wb_ack_o                  = s_q.ack;
   assign pin_o                     = s_q.pin_out;
   assign pin_oe_o                  = s_q.pin_oe;
   assign remap_pin_zero_in_o       = s_q.rp0_in;
   assign remap_pin_one_in_o        = s_q.rp1_in;
   assign host_port_addr_six_in_o   = s_q.ha6_in;
   assign host_port_addr_seven_in_o = s_q.ha7_in;
   assign bandgap_drive_o           = s_q.bg;

   // =========================================================
   // Checks.
   // =========================================================
   sequence seq_access;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      (seq_access and ce_i) |=> wb_ack_o)
      else $error("Bus access not acknowledged in one cycle.");
   AST_CMPREF_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_q.func[GPIOP_FN_CMPREF] |=> !pin_oe_o[GPIOP_PIN_TWO])
      else $error("Reference pin still driven.");
   AST_ANALOG_IN: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_q.ansel[GPIOP_PIN_TWO + 1] |=> !s_q.level[GPIOP_PIN_TWO + 1])
      else $error("Analog pin reads a digital level.");
   AST_OUT_DIR: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !s_q.dir[GPIOP_PIN_TWO + 1] |=> pin_oe_o[GPIOP_PIN_TWO + 1] && pin_o[GPIOP_PIN_TWO + 1]
         == $past(s_q.drive[GPIOP_PIN_TWO + 1]))
      else $error("Output pin not driving latch.");
   AST_BG_HIZ: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_q.wdctl[GPIOP_WD_BGOE] |=> bandgap_drive_o && !pin_oe_o[GPIOP_PIN_ONE])
      else $error("Bandgap output not applied.");
   AST_REMAP_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_q.func == (1 << GPIOP_FN_REMAP0) && !s_q.dir[GPIOP_PIN_ZERO]
         |=> pin_oe_o[GPIOP_PIN_ZERO] && pin_o[GPIOP_PIN_ZERO] == $past(remap_pin_zero_out_i))
      else $error("Remap output wrong.");
   AST_HA7_IN: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_q.func == (1 << GPIOP_FN_HADDR7) && s_q.wdctl == 8'h00 && s_q.dir[GPIOP_PIN_ONE]
         |=> !pin_oe_o[GPIOP_PIN_ONE])
      else $error("Address seven pin driven in input mode.");
   AST_DRIVE_WR: assert property (@(posedge clk_i) disable iff (rst_i)
      (seq_access and (ce_i && wb_we_i && wb_sel_i[0] && wb_adr_i == GPIOP_OFF_LEVEL))
         |=> s_q.drive[GPIOP_WIDTH-1:0] == $past(wb_dat_i[7:0]))
      else $error("Level write did not load the latch.");
endmodule

// *** core/gpiop_pkg.sv ***
// Overview of operation
// - Up to five ports, count set per variant.
// - Each port: direction, pin-level, drive registers.
// - Pin-level read returns actual pin levels.
// - Drive register read returns latched drive value.
// - Enabled peripheral takes the pin from GPIO.
// - Input active at direction 0 and 1; analog disables it.
// - Direction 0 drives latch; analog leaves output.
// - Analog selected after reset; output unaffected.
// - Reference output disables digital in and out.
// - Any analog function disables that pin's input.
// - Bandgap output only when control bit 4 set.
// - Don't-care functions override the direction bit.
// - Remap pin: input at 1, peripheral output at 0.
// - Address-seven pin: output at 0, input at 1.
package gpiop_pkg;
   // =========================================================
   // Register map: each port takes a block of four words.
   // =========================================================
   localparam int          GPIOP_PORTS_MAX   = 5;
   localparam int          GPIOP_WIDTH       = 8;
   localparam logic [7:0]  GPIOP_OFF_DIR     = 8'h00;
   localparam logic [7:0]  GPIOP_OFF_LEVEL   = 8'h04;
   localparam logic [7:0]  GPIOP_OFF_DRIVE   = 8'h08;
   localparam logic [7:0]  GPIOP_OFF_ANSEL   = 8'h0C;
   localparam logic [7:0]  GPIOP_PORT_STRIDE = 8'h10;
   localparam logic [7:0]  GPIOP_OFF_FUNC    = 8'h50;
   localparam logic [7:0]  GPIOP_OFF_WDCTL   = 8'h54;
   localparam logic [7:0]  GPIOP_DIR_RESET   = 8'hFF;
   localparam logic [7:0]  GPIOP_ANSEL_RESET = 8'hFF;
   // Function enable bits (special pins are port 0 bits 0..2).
   localparam int          GPIOP_FN_REMAP0   = 0;
   localparam int          GPIOP_FN_REMAP1   = 1;
   localparam int          GPIOP_FN_HADDR6   = 2;
   localparam int          GPIOP_FN_HADDR7   = 3;
   localparam int          GPIOP_FN_CMPREF   = 4;
   localparam int          GPIOP_FN_WIDTH    = 5;
   localparam int          GPIOP_WD_BGOE     = 4;
   localparam int          GPIOP_PIN_ZERO    = 0;
   localparam int          GPIOP_PIN_ONE     = 1;
   localparam int          GPIOP_PIN_TWO     = 2;
endpackage

// *** core/gpiop_pin_if.sv ***
`timescale 1ns/10ps
interface gpiop_pin_if;
   logic dir;
   logic drive;
   logic analog;
   logic pin_in;
   logic ovr_en;
   logic ovr_oe;
   logic ovr_out;
   logic in_kill;
   logic pad_o;
   logic pad_oe;
   logic din;
   modport port (input dir, drive, analog, pin_in, ovr_en, ovr_oe, ovr_out, in_kill,
                 output pad_o, pad_oe, din);
   modport ctrl (output dir, drive, analog, pin_in, ovr_en, ovr_oe, ovr_out, in_kill,
                 input pad_o, pad_oe, din);
endinterface

// *** core/gpiop_pin.sv ***
`timescale 1ns/10ps
module gpiop_pin (
   gpiop_pin_if.port p
);
   import gpiop_pkg::*;
   // A peripheral override decides direction itself; otherwise 0 means output.
   always_comb begin
      if (p.ovr_en) begin
         p.pad_oe = p.ovr_oe;
         p.pad_o  = p.ovr_out;
      end else begin
         p.pad_oe = ~p.dir;
         p.pad_o  = p.drive;
      end
      // The input buffer is gated off under analog use so that the level reads zero.
      p.din = p.pin_in & ~p.analog & ~p.in_kill;
   end
endmodule

// *** testbench/gpiop_pads_model.sv ***
`timescale 1ns/10ps
// =========================================================
// Board side of the pads
// =========================================================
module gpiop_pads_model #(
   parameter int N = 40
) (
   input  wire logic [N-1:0] pin_o_i,
   input  wire logic [N-1:0] pin_oe_i,
   input  wire logic [N-1:0] ext_val_i,
   input  wire logic [N-1:0] ext_en_i,
   output logic      [N-1:0] pin_i_o
);
   // A pad that nobody drives goes to the board pull-up, so a stale level can never pass as a read.
   always_comb begin
      for (int i = 0; i < N; i++) begin
         pin_i_o[i] = pin_oe_i[i] ? pin_o_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'h1);
      end
   end
endmodule

// *** testbench/gpiop_top_bench.sv ***
`timescale 1ns/10ps
module gpiop_top_bench;
   import gpiop_pkg::*;
   localparam int PORTS = 5;
   localparam int N     = PORTS * GPIOP_WIDTH;
   logic          clk_i = 1'h0;
   logic          rst_i = 1'h1;
   logic          ce_i  = 1'h1;
   logic [7:0]    wb_adr_i = 8'h00;
   logic [31:0]   wb_dat_i = 32'h0;
   logic [3:0]    wb_sel_i = 4'h0;
   logic          wb_we_i  = 1'h0;
   logic          wb_cyc_i = 1'h0;
   logic          wb_stb_i = 1'h0;
   logic [31:0]   wb_dat_o;
   logic          wb_ack_o;
   logic [N-1:0]  pin_i, pin_o, pin_oe, ext_val, ext_en;
   logic          r0_out = 1'h0, r1_out = 1'h0, a6_out = 1'h0, a6_oe = 1'h0, a7_out = 1'h0;
   logic          r0_in, r1_in, a6_in, a7_in, bg;
   logic [31:0]   rd;
   logic [7:0]    b;
   int            errors = 0;
   int            checks_done = 0;

   always #20 clk_i = ~clk_i;

   gpiop_top #(.PORTS(PORTS)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe),
      .remap_pin_zero_out_i(r0_out), .remap_pin_one_out_i(r1_out), .remap_pin_zero_in_o(r0_in),
      .remap_pin_one_in_o(r1_in), .host_port_addr_six_out_i(a6_out), .host_port_addr_six_oe_i(a6_oe),
      .host_port_addr_six_in_o(a6_in), .host_port_addr_seven_out_i(a7_out),
      .host_port_addr_seven_in_o(a7_in), .bandgap_drive_o(bg));

   gpiop_pads_model #(.N(N)) board (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_val_i(ext_val),
      .ext_en_i(ext_en), .pin_i_o(pin_i));

   // =========================================================
   // Bus and checking tasks
   // =========================================================
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // The request is held until ack is sampled high or 50 cycles pass, which counts as an error; no fixed answer time is assumed.
   task automatic wb(input logic [7:0] a, input logic we, input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_adr_i <= a;
      wb_we_i  <= we;
      wb_dat_i <= {24'h0, d};
      wb_sel_i <= s;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      if (n >= 50) begin
         errors++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(a, 1'h1, d, 4'hF);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      wb(a, 1'h0, 8'h00, 4'hF);
      chk(rd, {32'h0, exp});
   endtask

   task automatic settle;
      repeat (3) @(posedge clk_i);
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      conclude();
   end

   // =========================================================
   // Tests
   // =========================================================
   initial begin
      ext_val = '0;
      ext_en  = '1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'h0;
      for (int p = 0; p < PORTS; p++) begin
         b = 8'(p * 16);
         rdchk(b + GPIOP_OFF_DIR, GPIOP_DIR_RESET);
         rdchk(b + GPIOP_OFF_ANSEL, 8'hFF);
         rdchk(b + GPIOP_OFF_DRIVE, 8'h00);
      end
      chk(pin_oe, 40'h0);
      $display("test reset state done");
      for (int p = 0; p < PORTS; p++) begin
         b = 8'(p * 16);
         wr(b + GPIOP_OFF_DIR, 8'h00);
         wr(b + GPIOP_OFF_DRIVE, 8'hA5 ^ 8'(p));
         settle();
         chk(pin_o[p*8 +: 8], 8'hA5 ^ 8'(p));
         chk(pin_oe[p*8 +: 8], 8'hFF);
         rdchk(b + GPIOP_OFF_LEVEL, 8'h00);
         wr(b + GPIOP_OFF_ANSEL, 8'h00);
         settle();
         rdchk(b + GPIOP_OFF_LEVEL, 8'hA5 ^ 8'(p));
         wr(b + GPIOP_OFF_LEVEL, 8'h3C);
         settle();
         rdchk(b + GPIOP_OFF_DRIVE, 8'h3C);
         chk(pin_o[p*8 +: 8], 8'h3C);
         wr(b + GPIOP_OFF_DIR, 8'hF0);
         ext_val[p*8 +: 8] <= 8'hC3;
         settle();
         rdchk(b + GPIOP_OFF_DIR, 8'hF0);
         rdchk(b + GPIOP_OFF_LEVEL, 8'hCC);
         rdchk(b + GPIOP_OFF_DRIVE, 8'h3C);
         chk(pin_oe[p*8 +: 8], 8'h0F);
      end
      $display("test port paths done");
      wr(8'h58, 8'hFF);
      rdchk(8'h58, 8'h00);
      wb(GPIOP_OFF_DRIVE, 1'h1, 8'hFF, 4'hE);
      rdchk(GPIOP_OFF_DRIVE, 8'h3C);
      $display("test refusals done");
      wr(GPIOP_OFF_DIR, 8'h00);
      wr(GPIOP_OFF_FUNC, 8'h01);
      r0_out <= 1'h1;
      settle();
      chk({pin_oe[0], pin_o[0]}, 2'h3);
      wr(GPIOP_OFF_DIR, 8'h01);
      ext_val[0] <= 1'h0;
      settle();
      chk({pin_oe[0], r0_in}, 2'h0);
      ext_val[0] <= 1'h1;
      settle();
      chk(r0_in, 1'h1);
      wr(GPIOP_OFF_FUNC, 8'h05);
      a6_oe  <= 1'h1;
      a6_out <= 1'h1;
      settle();
      chk({pin_oe[0], pin_o[0]}, 2'h3);
      a6_oe <= 1'h0;
      settle();
      chk({pin_oe[0], a6_in}, 2'h1);
      wr(GPIOP_OFF_FUNC, 8'h08);
      wr(GPIOP_OFF_DIR, 8'h00);
      a7_out <= 1'h1;
      settle();
      chk({pin_oe[1], pin_o[1]}, 2'h3);
      wr(GPIOP_OFF_WDCTL, 8'h10);
      settle();
      chk({bg, pin_oe[1]}, 2'h2);
      wr(GPIOP_OFF_WDCTL, 8'h08);
      settle();
      chk({bg, pin_oe[1]}, 2'h1);
      wr(GPIOP_OFF_DIR, 8'h02);
      settle();
      chk({pin_oe[1], a7_in}, 2'h1);
      wr(GPIOP_OFF_FUNC, 8'h10);
      wr(GPIOP_OFF_DIR, 8'h00);
      settle();
      chk(pin_oe[7:0], 8'hFB);
      wr(GPIOP_OFF_DIR, 8'h04);
      ext_val[2] <= 1'h1;
      settle();
      rdchk(GPIOP_OFF_LEVEL, 8'h38);
      wr(GPIOP_OFF_FUNC, 8'h02);
      wr(GPIOP_OFF_DIR, 8'h00);
      r1_out <= 1'h1;
      settle();
      chk({pin_oe[1], pin_o[1]}, 2'h3);
      wr(GPIOP_OFF_DIR, 8'h02);
      ext_val[1] <= 1'h0;
      settle();
      chk({pin_oe[1], r1_in}, 2'h0);
      // With the clock enable low the sampled input must hold its old level.
      ce_i       <= 1'h0;
      ext_val[1] <= 1'h1;
      settle();
      chk(r1_in, 1'h0);
      ce_i <= 1'h1;
      settle();
      chk(r1_in, 1'h1);
      $display("test special pins done");
      conclude();
   end
endmodule
